// file: rtl/tuning_pkg.sv
package tuning_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Target address and direction
    localparam logic [6:0] TARGET_ADDR = 7'h6C;
    localparam logic       DIR_WRITE   = 1'b0;
    localparam logic       DIR_READ    = 1'b1;
    localparam logic [3:0] BYTE_BITS   = 4'h8;

    ////////////////////////////////////////////////////////////////////////////
    // Sub-addresses
    localparam logic [7:0] SUB_DEVICE_ID  = 8'h00;
    localparam logic [7:0] SUB_VERSION_ID = 8'h01;
    localparam logic [7:0] SUB_RX_EQ      = 8'h02;
    localparam logic [7:0] SUB_EDGE_RATE  = 8'h03;
    localparam logic [7:0] SUB_RESERVED4  = 8'h04;
    localparam logic [7:0] SUB_BOOST_SW   = 8'h05;
    localparam logic [7:0] RESERVED4_VAL  = 8'h08;

    ////////////////////////////////////////////////////////////////////////////
    // Field codes
    localparam logic [3:0] EQ_0DB      = 4'h0;
    localparam logic [3:0] EQ_3DB      = 4'h2;
    localparam logic [3:0] EQ_6DB      = 4'h6;
    localparam logic [3:0] EQ_9DB      = 4'hB;
    localparam logic [2:0] EDGE_250PS  = 3'h1;
    localparam logic [2:0] EDGE_200PS  = 3'h3;
    localparam logic [2:0] EDGE_150PS  = 3'h7;
    localparam logic [1:0] BOOST_0DB   = 2'h0;
    localparam logic [1:0] BOOST_1DB   = 2'h1;
    localparam logic [1:0] BOOST_3DB   = 2'h3;
    localparam logic [1:0] SWING_200MV = 2'h0;
    localparam logic [1:0] SWING_225MV = 2'h1;
    localparam logic [1:0] SWING_250MV = 2'h2;
    localparam logic [1:0] SWING_275MV = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions and defaults
    localparam int         BOOST_LSB     = 2;
    localparam logic [3:0] EQ_DEFAULT    = EQ_3DB;
    localparam logic [2:0] EDGE_DEFAULT  = EDGE_200PS;
    localparam logic [1:0] BOOST_DEFAULT = BOOST_1DB;
    localparam logic [1:0] SWING_DEFAULT = SWING_250MV;

    ////////////////////////////////////////////////////////////////////////////
    // State encodings
    typedef enum logic [8:0] {
        T_IDLE      = 9'h001,
        T_ADDR      = 9'h002,
        T_ADDR_ACK  = 9'h004,
        T_SUB       = 9'h008,
        T_SUB_ACK   = 9'h010,
        T_WDATA     = 9'h020,
        T_WDATA_ACK = 9'h040,
        T_RDATA     = 9'h080,
        T_RDATA_ACK = 9'h100
    } target_state_t;

    typedef enum logic [3:0] {
        H_IDLE  = 4'h1,
        H_START = 4'h2,
        H_BIT   = 4'h4,
        H_STOP  = 4'h8
    } master_state_t;

endpackage

// file: rtl/tuning_link_if.sv
interface tuning_link_if;
    logic host_scl_oe_n;
    logic host_scl_o;
    logic host_sda_oe_n;
    logic host_sda_o;
    logic dev_sda_oe_n;
    logic dev_sda_o;
    logic scl;
    logic sda;

    // Open-drain lines with pull-ups: wired-and of all drivers
    assign scl = host_scl_oe_n | host_scl_o;
    assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

    modport target (
        input  scl,
        input  sda,
        output dev_sda_oe_n,
        output dev_sda_o
    );

    modport master (
        input  sda,
        output host_scl_oe_n,
        output host_scl_o,
        output host_sda_oe_n,
        output host_sda_o
    );
endinterface

// file: rtl/lane_tuning_target.sv
module lane_tuning_target
    import tuning_pkg::*;
#(
    // Arbitrary identification values
    parameter logic [7:0] DEVICE_ID  = 8'h5A,
    parameter logic [7:0] VERSION_ID = 8'h01
)
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Reset pin
    input  wire logic       active_low_reset_pin,
    // Serial link
    tuning_link_if.target   link,
    // Tuning fields
    output logic [3:0]      rx_equalizer_gain,
    output logic [2:0]      tx_edge_rate_select,
    output logic [1:0]      tx_boost_level,
    output logic [1:0]      output_swing_select
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        target_state_t state;
        logic [3:0]    cnt;
        logic [7:0]    shift;
        logic [7:0]    sub;
        logic          dir;
        logic          ack_n;
        logic [3:0]    eq;
        logic [2:0]    edge_rate;
        logic [1:0]    boost;
        logic [1:0]    swing;
        logic          sda_oe_n;
        logic          sda_o;
        logic          scl_s1;
        logic          scl_s2;
        logic          scl_d;
        logic          sda_s1;
        logic          sda_s2;
        logic          sda_d;
        logic          active_low_reset_pin_s1;
        logic          active_low_reset_pin_s2;
        logic          active_low_reset_pin_d;
    } target_regs_t;

    // Sync stages idle high so no false edge follows reset
    localparam target_regs_t TARGET_RESET = '{
        state:     T_IDLE,
        eq:        EQ_DEFAULT,
        edge_rate: EDGE_DEFAULT,
        boost:     BOOST_DEFAULT,
        swing:     SWING_DEFAULT,
        sda_oe_n:  1'b1,
        ack_n:     1'b1,
        scl_s1:    1'b1,
        scl_s2:    1'b1,
        scl_d:     1'b1,
        sda_s1:    1'b1,
        sda_s2:    1'b1,
        sda_d:     1'b1,
        active_low_reset_pin_s1:   1'b1,
        active_low_reset_pin_s2:   1'b1,
        active_low_reset_pin_d:    1'b1,
        default:   '0
    };

    target_regs_t r_reg;
    target_regs_t r_next;

    ////////////////////////////////////////////////////////////////////////////
    // Register read mux

    function automatic logic [7:0] read_mux(
        input logic [7:0] sub,
        input logic [3:0] eq,
        input logic [2:0] edge_rate,
        input logic [1:0] boost,
        input logic [1:0] swing
    );
        logic [7:0] v;
        v = 8'h00;
        if (sub == SUB_DEVICE_ID)
            v = DEVICE_ID;
        else if (sub == SUB_VERSION_ID)
            v = VERSION_ID;
        else if (sub == SUB_RX_EQ)
            v = {4'h0, eq};
        else if (sub == SUB_EDGE_RATE)
            v = {5'h00, edge_rate};
        else if (sub == SUB_RESERVED4)
            v = RESERVED4_VAL;
        // boost and swing share one byte
        else if (sub == SUB_BOOST_SW)
            v = {4'h0, boost, swing};
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    logic       scl_rise;
    logic       scl_fall;
    logic       start_seen;
    logic       stop_seen;
    logic [7:0] rd_byte;

    always_comb
    begin
        r_next = r_reg;
        // Two-stage synchronisers, then an edge history stage
        r_next.scl_s1  = link.scl;
        r_next.scl_s2  = r_reg.scl_s1;
        r_next.scl_d   = r_reg.scl_s2;
        r_next.sda_s1  = link.sda;
        r_next.sda_s2  = r_reg.sda_s1;
        r_next.sda_d   = r_reg.sda_s2;
        r_next.active_low_reset_pin_s1 = active_low_reset_pin;
        r_next.active_low_reset_pin_s2 = r_reg.active_low_reset_pin_s1;
        r_next.active_low_reset_pin_d  = r_reg.active_low_reset_pin_s2;

        scl_rise   = r_reg.scl_s2 & ~r_reg.scl_d;
        scl_fall   = ~r_reg.scl_s2 & r_reg.scl_d;
        start_seen = r_reg.scl_s2 & r_reg.scl_d & r_reg.sda_d & ~r_reg.sda_s2;
        stop_seen  = r_reg.scl_s2 & r_reg.scl_d & ~r_reg.sda_d & r_reg.sda_s2;
        rd_byte    = read_mux(r_reg.sub, r_reg.eq, r_reg.edge_rate, r_reg.boost, r_reg.swing);

        if (!r_reg.active_low_reset_pin_s2)
        begin
            // Pin held low: defaults, link ignored
            r_next.state     = T_IDLE;
            r_next.sda_oe_n  = 1'b1;
            r_next.eq        = EQ_DEFAULT;
            r_next.edge_rate = EDGE_DEFAULT;
            r_next.boost     = BOOST_DEFAULT;
            r_next.swing     = SWING_DEFAULT;
        end
        else if (!r_reg.active_low_reset_pin_d)
        begin
            // strap level on the clock pin picks equalizer
            r_next.eq = r_reg.scl_s2 ? EQ_9DB : EQ_3DB;
        end
        else if (stop_seen)
        begin
            r_next.state    = T_IDLE;
            r_next.sda_oe_n = 1'b1;
        end
        else if (start_seen)
        begin
            // Sub-address survives a repeated start for the read
            r_next.state    = T_ADDR;
            r_next.cnt      = 4'h0;
            r_next.sda_oe_n = 1'b1;
        end
        else
        begin
            case (r_reg.state)
                T_ADDR, T_SUB, T_WDATA:
                begin
                    if (scl_rise)
                    begin
                        r_next.shift = {r_reg.shift[6:0], r_reg.sda_s2};
                        r_next.cnt   = r_reg.cnt + 4'h1;
                    end
                    else if (scl_fall && r_reg.cnt == BYTE_BITS)
                    begin
                        r_next.sda_oe_n = 1'b0;
                        if (r_reg.state == T_ADDR)
                        begin
                            if (r_reg.shift[7:1] == TARGET_ADDR)
                            begin
                                r_next.dir   = r_reg.shift[0];
                                r_next.state = T_ADDR_ACK;
                            end
                            else
                            begin
                                r_next.sda_oe_n = 1'b1;
                                r_next.state    = T_IDLE;
                            end
                        end
                        else if (r_reg.state == T_SUB)
                        begin
                            r_next.sub   = r_reg.shift;
                            r_next.state = T_SUB_ACK;
                        end
                        else
                        begin
                            r_next.state = T_WDATA_ACK;
                        end
                    end
                end
                T_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        r_next.cnt = 4'h0;
                        // direction 1 turns the bus to read
                        if (r_reg.dir == DIR_READ)
                        begin
                            r_next.shift    = rd_byte;
                            r_next.sda_oe_n = rd_byte[7];
                            r_next.state    = T_RDATA;
                        end
                        else
                        begin
                            r_next.sda_oe_n = 1'b1;
                            r_next.state    = T_SUB;
                        end
                    end
                end
                T_SUB_ACK:
                begin
                    if (scl_fall)
                    begin
                        r_next.sda_oe_n = 1'b1;
                        r_next.cnt      = 4'h0;
                        r_next.state    = T_WDATA;
                    end
                end
                T_WDATA_ACK:
                begin
                    if (scl_fall)
                    begin
                        r_next.sda_oe_n = 1'b1;
                        r_next.cnt      = 4'h0;
                        r_next.state    = T_WDATA;
                        // update at the acknowledge falling edge
                        if (r_reg.sub == SUB_RX_EQ)
                            r_next.eq = r_reg.shift[3:0];
                        else if (r_reg.sub == SUB_EDGE_RATE)
                            r_next.edge_rate = r_reg.shift[2:0];
                        else if (r_reg.sub == SUB_BOOST_SW)
                        begin
                            // swing in low bits, boost above
                            r_next.swing = r_reg.shift[1:0];
                            r_next.boost = r_reg.shift[BOOST_LSB +: 2];
                        end
                    end
                end
                T_RDATA:
                begin
                    if (scl_rise)
                        r_next.cnt = r_reg.cnt + 4'h1;
                    else if (scl_fall)
                    begin
                        if (r_reg.cnt == BYTE_BITS)
                        begin
                            r_next.sda_oe_n = 1'b1;
                            r_next.state    = T_RDATA_ACK;
                        end
                        else
                        begin
                            r_next.shift    = {r_reg.shift[6:0], 1'b0};
                            r_next.sda_oe_n = r_reg.shift[6];
                        end
                    end
                end
                T_RDATA_ACK:
                begin
                    if (scl_rise)
                        r_next.ack_n = r_reg.sda_s2;
                    else if (scl_fall)
                    begin
                        // Acknowledge repeats the same register, no increment
                        r_next.cnt = 4'h0;
                        if (!r_reg.ack_n)
                        begin
                            r_next.shift    = rd_byte;
                            r_next.sda_oe_n = rd_byte[7];
                            r_next.state    = T_RDATA;
                        end
                        else
                            r_next.state = T_IDLE;
                    end
                end
                default:
                begin
                    r_next.state    = T_IDLE;
                    r_next.sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            r_reg <= TARGET_RESET;
        else
            r_reg <= r_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign link.dev_sda_oe_n   = r_reg.sda_oe_n;
    assign link.dev_sda_o      = r_reg.sda_o;
    assign rx_equalizer_gain   = r_reg.eq;
    assign tx_edge_rate_select = r_reg.edge_rate;
    assign tx_boost_level      = r_reg.boost;
    assign output_swing_select = r_reg.swing;

endmodule

// file: rtl/lane_tuning_master.sv
module lane_tuning_master
    import tuning_pkg::*;
#(
    // Clocks per step of the serial clock; one bit takes three steps
    parameter int TICK_CYCLES = 8
)
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Serial link
    tuning_link_if.master   link,
    // Command
    input  wire logic       cmd_valid,
    input  wire logic       cmd_read,
    input  wire logic [7:0] cmd_sub_addr,
    input  wire logic [7:0] cmd_wr_data,
    // Status
    output logic            busy,
    output logic            done,
    output logic            nack,
    output logic [7:0]      rd_data
);

    localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);

    typedef struct packed {
        master_state_t state;
        logic [7:0]    tick;
        logic [1:0]    step;
        logic [3:0]    bc;
        logic [1:0]    idx;
        logic          rd;
        logic [7:0]    sub;
        logic [7:0]    wdat;
        logic [7:0]    shift;
        logic          scl_oe_n;
        logic          sda_oe_n;
        logic          sda_s1;
        logic          sda_s2;
        logic          busy;
        logic          done;
        logic          nack;
        logic [7:0]    rd_data;
    } master_regs_t;

    localparam master_regs_t MASTER_RESET = '{
        state:    H_IDLE,
        scl_oe_n: 1'b1,
        sda_oe_n: 1'b1,
        sda_s1:   1'b1,
        sda_s2:   1'b1,
        default:  '0
    };

    master_regs_t r_reg;
    master_regs_t r_next;

    ////////////////////////////////////////////////////////////////////////////
    // Byte sequence of a transfer

    function automatic logic [7:0] seq_byte(
        input logic [1:0] idx,
        input logic       rd,
        input logic [7:0] sub,
        input logic [7:0] wdat
    );
        logic [7:0] v;
        v = 8'hFF;
        // first byte always carries direction 0
        if (idx == 2'h0)
            v = {TARGET_ADDR, DIR_WRITE};
        else if (idx == 2'h1)
            v = sub;
        else if (idx == 2'h2)
            v = rd ? {TARGET_ADDR, DIR_READ} : wdat;
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    logic tick;
    logic rd_byte;

    always_comb
    begin
        r_next        = r_reg;
        r_next.sda_s1 = link.sda;
        r_next.sda_s2 = r_reg.sda_s1;
        r_next.done   = 1'b0;
        tick          = (r_reg.tick == TICK_LAST);
        rd_byte       = r_reg.rd && r_reg.idx == 2'h3;
        r_next.tick   = tick ? 8'h00 : r_reg.tick + 8'h01;

        case (r_reg.state)
            H_IDLE:
            begin
                r_next.tick = 8'h00;
                if (cmd_valid)
                begin
                    r_next.state = H_START;
                    r_next.step  = 2'h0;
                    r_next.idx   = 2'h0;
                    r_next.rd    = cmd_read;
                    r_next.sub   = cmd_sub_addr;
                    r_next.wdat  = cmd_wr_data;
                    r_next.busy  = 1'b1;
                    r_next.nack  = 1'b0;
                end
            end
            H_START:
            begin
                if (tick)
                begin
                    r_next.step = r_reg.step + 2'h1;
                    case (r_reg.step)
                        2'h0: r_next.sda_oe_n = 1'b1;
                        2'h1: r_next.scl_oe_n = 1'b1;
                        2'h2: r_next.sda_oe_n = 1'b0;
                        default:
                        begin
                            r_next.scl_oe_n = 1'b0;
                            r_next.state    = H_BIT;
                            r_next.bc       = 4'h0;
                            r_next.shift    = seq_byte(r_reg.idx, r_reg.rd, r_reg.sub, r_reg.wdat);
                        end
                    endcase
                end
            end
            H_BIT:
            begin
                if (tick)
                begin
                    r_next.step = r_reg.step + 2'h1;
                    if (r_reg.step == 2'h0)
                        // Release for read data, and NACK the single read byte
                        r_next.sda_oe_n = (r_reg.bc == BYTE_BITS) || rd_byte || r_reg.shift[7];
                    else if (r_reg.step == 2'h1)
                        r_next.scl_oe_n = 1'b1;
                    else
                    begin
                        r_next.scl_oe_n = 1'b0;
                        r_next.step     = 2'h0;
                        r_next.bc       = r_reg.bc + 4'h1;
                        if (r_reg.bc != BYTE_BITS)
                            r_next.shift = {r_reg.shift[6:0], r_reg.sda_s2};
                        else if (!rd_byte && r_reg.sda_s2)
                        begin
                            r_next.nack  = 1'b1;
                            r_next.state = H_STOP;
                        end
                        else if (rd_byte || (!r_reg.rd && r_reg.idx == 2'h2))
                        begin
                            r_next.rd_data = rd_byte ? r_reg.shift : r_reg.rd_data;
                            r_next.state   = H_STOP;
                        end
                        else if (r_reg.rd && r_reg.idx == 2'h1)
                        begin
                            // repeated start before the read address
                            r_next.idx   = 2'h2;
                            r_next.state = H_START;
                        end
                        else
                        begin
                            r_next.idx   = r_reg.idx + 2'h1;
                            r_next.bc    = 4'h0;
                            r_next.shift = seq_byte(r_reg.idx + 2'h1, r_reg.rd, r_reg.sub, r_reg.wdat);
                        end
                    end
                end
            end
            H_STOP:
            begin
                if (tick)
                begin
                    r_next.step = r_reg.step + 2'h1;
                    if (r_reg.step == 2'h0)
                        r_next.sda_oe_n = 1'b0;
                    else if (r_reg.step == 2'h1)
                        r_next.scl_oe_n = 1'b1;
                    else
                    begin
                        r_next.sda_oe_n = 1'b1;
                        r_next.state    = H_IDLE;
                        r_next.busy     = 1'b0;
                        r_next.done     = 1'b1;
                    end
                end
            end
            default:
                r_next = MASTER_RESET;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            r_reg <= MASTER_RESET;
        else
            r_reg <= r_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign link.host_scl_oe_n = r_reg.scl_oe_n;
    assign link.host_scl_o    = 1'b0;
    assign link.host_sda_oe_n = r_reg.sda_oe_n;
    assign link.host_sda_o    = 1'b0;
    assign busy               = r_reg.busy;
    assign done               = r_reg.done;
    assign nack               = r_reg.nack;
    assign rd_data            = r_reg.rd_data;

endmodule

// file: sim/tuning_sva.sv
module tuning_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link lines
    input wire logic host_scl_oe_n,
    input wire logic host_scl_o,
    input wire logic host_sda_oe_n,
    input wire logic host_sda_o,
    input wire logic dev_sda_oe_n,
    input wire logic dev_sda_o,
    input wire logic scl,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_od; !host_scl_o && !host_sda_o && !dev_sda_o; endproperty
    a_od: assert property (p_od) else $error("open-drain data not low");
    property p_dev_scl_low; $changed(dev_sda_oe_n) |-> !scl; endproperty
    a_dev_scl_low: assert property (p_dev_scl_low) else $error("target moved sda with scl high");
    property p_dev_hold; $fell(dev_sda_oe_n) |-> !dev_sda_oe_n [*8]; endproperty
    a_dev_hold: assert property (p_dev_hold) else $error("target drive too short");
    property p_scl_high; $rose(scl) |-> scl [*6]; endproperty
    a_scl_high: assert property (p_scl_high) else $error("scl high phase short");
    property p_scl_low; $fell(scl) |-> !scl [*6]; endproperty
    a_scl_low: assert property (p_scl_low) else $error("scl low phase short");
    property p_start; $fell(sda) && scl |-> ##[1:20] !scl; endproperty
    a_start: assert property (p_start) else $error("start not followed by clock");
    property p_stop; $rose(sda) && scl |-> scl [*6]; endproperty
    a_stop: assert property (p_stop) else $error("bus not idle after stop");
    property p_release; $fell(rst) |-> host_scl_oe_n && host_sda_oe_n && dev_sda_oe_n; endproperty
    a_release: assert property (p_release) else $error("lines held after reset");
endmodule

// file: sim/testbench.sv
module testbench;
    import tuning_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       active_low_reset_pin = 1'b1;
    logic       cmd_valid = 1'b0;
    logic       cmd_read = 1'b0;
    logic [7:0] cmd_sub_addr = 8'h00;
    logic [7:0] cmd_wr_data = 8'h00;
    logic       busy, done, nack;
    logic [7:0] rd_data;
    logic [3:0] rx_equalizer_gain;
    logic [2:0] tx_edge_rate_select;
    logic [1:0] tx_boost_level, output_swing_select;
    int         n_mismatch = 0;
    int         comparisons = 0;
    int         cycles = 0;
    tuning_link_if link ();
    // Arbitrary identification value
    lane_tuning_target #(.DEVICE_ID(8'h3C)) lane_tuning_target_i (.clk(clk), .rst(rst),
        .active_low_reset_pin(active_low_reset_pin), .link(link), .rx_equalizer_gain(rx_equalizer_gain),
        .tx_edge_rate_select(tx_edge_rate_select), .tx_boost_level(tx_boost_level),
        .output_swing_select(output_swing_select));
    lane_tuning_master lane_tuning_master_i (.clk(clk), .rst(rst), .link(link), .cmd_valid(cmd_valid),
        .cmd_read(cmd_read), .cmd_sub_addr(cmd_sub_addr), .cmd_wr_data(cmd_wr_data), .busy(busy),
        .done(done), .nack(nack), .rd_data(rd_data));
    tuning_sva tuning_sva_i (.clk(clk), .rst(rst), .host_scl_oe_n(link.host_scl_oe_n),
        .host_scl_o(link.host_scl_o), .host_sda_oe_n(link.host_sda_oe_n), .host_sda_o(link.host_sda_o),
        .dev_sda_oe_n(link.dev_sda_oe_n), .dev_sda_o(link.dev_sda_o), .scl(link.scl), .sda(link.sda));
    always #4 clk = ~clk;
    ////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic rd, input logic [7:0] sub, input logic [7:0] dat);
        @(posedge clk) #1;
        cmd_valid = 1'b1;
        cmd_read = rd;
        cmd_sub_addr = sub;
        cmd_wr_data = dat;
        @(posedge clk) #1;
        cmd_valid = 1'b0;
        chk("busy", 8'h01, {7'h0, busy});
        // Bounded wait: a frame is well under 2000 cycles; running out counts as a mismatch
        for (int i = 0; i < 2000 && done !== 1'b1; i++) @(posedge clk) #1;
        chk("done", 8'h01, {7'h0, done});
        chk("busy end", 8'h00, {7'h0, busy});
        chk("nack", 8'h00, {7'h0, nack});
    endtask
    task automatic t_regs;
        logic [7:0] sub [6] = '{8'h02, 8'h03, 8'h05, 8'h00, 8'h04, 8'h07};
        logic [7:0] wr [6] = '{8'hF6, 8'hFB, 8'hFE, 8'hFF, 8'hFF, 8'hFF};
        logic [7:0] ex [6] = '{8'h06, 8'h03, 8'h0E, 8'h3C, 8'h08, 8'h00};
        for (int i = 0; i < 6; i++)
        begin
            xfer(1'b0, sub[i], wr[i]);
            xfer(1'b1, sub[i], 8'h00);
            chk("read back", ex[i], rd_data);
        end
        $display("test regs done");
    endtask
    task automatic t_codes;
        logic [3:0] eqc [4] = '{4'h0, 4'h2, 4'h6, 4'hB};
        logic [2:0] edc [4] = '{3'h1, 3'h3, 3'h7, 3'h7};
        logic [1:0] bsc [4] = '{2'h0, 2'h1, 2'h3, 2'h3};
        for (int i = 0; i < 4; i++)
        begin
            xfer(1'b0, 8'h02, {4'h0, eqc[i]});
            xfer(1'b0, 8'h03, {5'h0, edc[i]});
            xfer(1'b0, 8'h05, {4'h0, bsc[i], i[1:0]});
            chk("eq", {4'h0, eqc[i]}, {4'h0, rx_equalizer_gain});
            chk("edge", {5'h0, edc[i]}, {5'h0, tx_edge_rate_select});
            chk("boost", {6'h0, bsc[i]}, {6'h0, tx_boost_level});
            chk("swing", {6'h0, i[1:0]}, {6'h0, output_swing_select});
        end
        $display("test codes done");
    endtask
    task automatic t_strap;
        xfer(1'b0, 8'h02, 8'h00);
        active_low_reset_pin = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk("eq dflt", {4'h0, EQ_DEFAULT}, {4'h0, rx_equalizer_gain});
        chk("edge dflt", {5'h0, EDGE_200PS}, {5'h0, tx_edge_rate_select});
        chk("boost dflt", {6'h0, BOOST_1DB}, {6'h0, tx_boost_level});
        chk("swing dflt", {6'h0, SWING_250MV}, {6'h0, output_swing_select});
        // Idle scl is high, so the strap reads high
        active_low_reset_pin = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        chk("eq strap", 8'h0B, {4'h0, rx_equalizer_gain});
        xfer(1'b0, 8'h02, 8'h06);
        chk("eq override", 8'h06, {4'h0, rx_equalizer_gain});
        $display("test strap done");
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 50000)
        begin
            n_mismatch++;
            end_sim();
        end
    end
    initial
    begin
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        t_regs();
        t_codes();
        t_strap();
        end_sim();
    end
endmodule
